// ===== common/batt_map.svh
`ifndef BATT_MAP_SVH
`define BATT_MAP_SVH
// function codes served here
`define FC_STATUS 8'h16
`define FC_CYCLES 8'h17
`define FC_DESIGN_CAP 8'h18
`define FC_DESIGN_VOLT 8'h19
`define FC_SPEC_INFO 8'h1a
`define FC_BUILD_DATE 8'h1b
`define FC_SERIAL 8'h1c
`define FC_MAKER 8'h20
// reserved and optional manufacturer code ranges
`define FC_RSV_LO 8'h1d
`define FC_RSV_HI 8'h1f
`define FC_MFR_LO 8'h30
`define FC_MFR_HI 8'h3f
`define FC_RSV_TOP 8'h40
// eeprom image addresses
`define EE_CYCLES_LO 7'h0e
`define EE_CYCLES_HI 7'h0f
`define EE_VOLT_LO 7'h12
`define EE_SPEC_LO 7'h14
`define EE_DATE_LO 7'h16
`define EE_SERIAL_LO 7'h18
`define EE_MAKER_LO 7'h20
`define EE_THRESH_LO 7'h3c
`define EE_THRESH_HI 7'h3d
`define EE_FC_CLEAR 7'h4c
`define EE_CAP_MAH_LO 7'h60
`define EE_CAP_MWH_LO 7'h62
// error codes
`define ERR_OK 3'h0
`define ERR_BUSY 3'h1
`define ERR_RESERVED 3'h2
`define ERR_UNSUPPORTED 3'h3
`define ERR_DENIED 3'h4
`define ERR_OVERFLOW 3'h5
`define ERR_BAD_SIZE 3'h6
`define ERR_UNKNOWN 3'h7
// sizes and limits
`define WORD_LEN 6'h02
`define MAKER_LEN 6'h0b
`define MAX_BLOCK 6'h20
`define DSG_CLEAR_PCT 8'h14
`define CYCLES_MAX 16'hffff
`endif

// ===== common/batt_pkg.sv
package batt_pkg;
  // host request as presented on the command port
  typedef struct packed {
    logic write;
    logic [7:0] code;
    logic [5:0] len;
  } cmd_type;
  // answer to the host
  typedef struct packed {
    logic [15:0] data;
    logic [2:0] err;
    logic last;
  } rsp_type;
  // request sequencer states
  typedef enum logic [0:0] {ST_IDLE, ST_RUN} state_type;
endpackage

// ===== hdl/status_flag.sv
`timescale 1ns/1ns
// sticky status flag: set beats clear in the same cycle
module status_flag (
  input wire logic mclk,
  input wire logic reset,
  input wire logic set,
  input wire logic clr,
  output logic state_q
);
  always_ff @(posedge mclk) begin
    if (reset) begin
      state_q <= 1'b0;
    end else if (set) begin
      state_q <= 1'b1;
    end else if (clr) begin
      state_q <= 1'b0;
    end
  end
endmodule

// ===== hdl/shadow_mem.sv
`timescale 1ns/1ns
// eeprom image copy, one write and one registered read port
module shadow_mem (
  input wire logic mclk,
  input wire logic wr_en,
  input wire logic [6:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic [6:0] rd_addr,
  output logic [7:0] rd_data_q
);
  logic [7:0] mem [0:127]; // byte array
  // write port
  always_ff @(posedge mclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end
  // read data leaves through a register
  always_ff @(posedge mclk) begin
    rd_data_q <= mem[rd_addr];
  end
endmodule

// ===== hdl/battery_status_and_identity_words.sv
`timescale 1ns/1ns
`include "batt_map.svh"
module battery_status_and_identity_words (
  input wire logic mclk,
  input wire logic reset,
  input wire batt_pkg::cmd_type cmd,
  input wire logic cmd_valid,
  output logic cmd_ready_q,
  output batt_pkg::rsp_type rsp_q,
  output logic rsp_valid_q,
  input wire logic ee_wr_valid,
  input wire logic [6:0] ee_wr_addr,
  input wire logic [7:0] ee_wr_data,
  input wire logic ee_load_ok,
  input wire logic ee_load_bad,
  input wire logic charging_seen,
  input wire logic not_charging_seen,
  input wire logic charge_termination,
  input wire logic overcharge_seen,
  input wire logic second_end_voltage_threshold,
  input wire logic [7:0] charge_percent,
  input wire logic capacity_mode,
  input wire logic [7:0] alarm_bits,
  input wire logic dsg_unit_pulse,
  output logic ee_store_valid_q,
  output logic [6:0] ee_store_addr_q,
  output logic [7:0] ee_store_data_q,
  input wire logic ee_store_ready,
  output logic [15:0] status_word_q
);
  // ==========================================================
  // status flags
  logic eeprom_load_valid; // image accepted
  logic not_charging; // no charge seen
  logic fully_charged; // charge ended
  logic fully_discharged; // pack at low voltage
  logic [7:0] fc_clear_q; // full-flag clear percentage
  logic fc_clear_hit; // percent at or below clear level
  logic dsg_clear_hit; // percent at or above release level
  assign fc_clear_hit = charge_percent <= fc_clear_q;
  assign dsg_clear_hit = charge_percent >= `DSG_CLEAR_PCT;
  status_flag u_load_flag (
    .mclk(mclk), .reset(reset), .set(ee_load_ok), .clr(ee_load_bad), .state_q(eeprom_load_valid));
  status_flag u_idle_flag (
    .mclk(mclk), .reset(reset), .set(not_charging_seen), .clr(charging_seen), .state_q(not_charging));
  status_flag u_full_flag (
    .mclk(mclk), .reset(reset), .set(charge_termination | overcharge_seen), .clr(fc_clear_hit),
    .state_q(fully_charged));
  status_flag u_empty_flag (
    .mclk(mclk), .reset(reset), .set(second_end_voltage_threshold), .clr(dsg_clear_hit),
    .state_q(fully_discharged));

  // ==========================================================
  // values caught while the eeprom image streams in, discharge counting and count write-back
  logic [15:0] thresh_q; // discharge units per cycle
  logic [15:0] dsg_acc_q; // units since last cycle step
  logic [15:0] wear_cycle_total_q; // cycle count
  logic cycle_step; // one more cycle reached
  logic [1:0] store_cnt_q; // bytes left to store
  logic store_busy; // store in flight
  assign cycle_step = dsg_unit_pulse && (thresh_q != 16'h0000) && (dsg_acc_q + 16'h0001 >= thresh_q);
  assign store_busy = store_cnt_q != 2'h0;
  // snoop the load for clear level and threshold
  always_ff @(posedge mclk) begin
    if (reset) begin
      fc_clear_q <= 8'h00;
      thresh_q <= 16'h0000;
    end else if (ee_wr_valid) begin
      if (ee_wr_addr == `EE_FC_CLEAR) begin
        fc_clear_q <= ee_wr_data;
      end
      if (ee_wr_addr == `EE_THRESH_LO) begin
        thresh_q[7:0] <= ee_wr_data;
      end
      if (ee_wr_addr == `EE_THRESH_HI) begin
        thresh_q[15:8] <= ee_wr_data;
      end
    end
  end
  // discharge accumulator
  always_ff @(posedge mclk) begin
    if (reset) begin
      dsg_acc_q <= 16'h0000;
    end else if (cycle_step) begin
      dsg_acc_q <= 16'h0000;
    end else if (dsg_unit_pulse) begin
      dsg_acc_q <= dsg_acc_q + 16'h0001;
    end
  end
  // cycle counter: loaded from image, saturating step
  always_ff @(posedge mclk) begin
    if (reset) begin
      wear_cycle_total_q <= 16'h0000;
    end else if (ee_wr_valid && ee_wr_addr == `EE_CYCLES_LO) begin
      wear_cycle_total_q[7:0] <= ee_wr_data;
    end else if (ee_wr_valid && ee_wr_addr == `EE_CYCLES_HI) begin
      wear_cycle_total_q[15:8] <= ee_wr_data;
    end else if (cycle_step && wear_cycle_total_q != `CYCLES_MAX) begin
      wear_cycle_total_q <= wear_cycle_total_q + 16'h0001;
    end
  end
  // write the new count back, low byte then high byte
  always_ff @(posedge mclk) begin
    if (reset) begin
      store_cnt_q <= 2'h0;
      ee_store_valid_q <= 1'b0;
      ee_store_addr_q <= 7'h00;
      ee_store_data_q <= 8'h00;
    end else if (cycle_step && wear_cycle_total_q != `CYCLES_MAX) begin
      store_cnt_q <= 2'h2;
      ee_store_valid_q <= 1'b0;
    end else if (store_busy && !ee_store_valid_q) begin
      // present the next byte
      ee_store_valid_q <= 1'b1;
      ee_store_addr_q <= (store_cnt_q == 2'h2) ? `EE_CYCLES_LO : `EE_CYCLES_HI;
      ee_store_data_q <= (store_cnt_q == 2'h2) ? wear_cycle_total_q[7:0] : wear_cycle_total_q[15:8];
    end else if (ee_store_valid_q && ee_store_ready) begin
      // byte taken by the eeprom side
      ee_store_valid_q <= 1'b0;
      store_cnt_q <= store_cnt_q - 2'h1;
    end
  end

  // ==========================================================
  // request decode
  logic accept; // request taken this cycle
  logic [2:0] err_d; // outcome of the offered code
  logic [2:0] err_q; // outcome of last processed code
  logic from_eeprom; // answer comes from the image
  logic [6:0] src_lo; // first image byte of answer
  logic [5:0] exp_len; // legal block size for the code
  logic is_word; // word-sized function
  assign accept = cmd_valid && cmd_ready_q;
  assign is_word = cmd.code >= `FC_STATUS && cmd.code <= `FC_SERIAL;
  assign exp_len = (cmd.code == `FC_MAKER) ? `MAKER_LEN + 6'h01 : `WORD_LEN;
  assign from_eeprom = (cmd.code >= `FC_DESIGN_CAP && cmd.code <= `FC_SERIAL) || cmd.code == `FC_MAKER;
  // image address per code
  always_comb begin
    unique case (cmd.code)
      `FC_DESIGN_CAP: src_lo = capacity_mode ? `EE_CAP_MWH_LO : `EE_CAP_MAH_LO;
      `FC_DESIGN_VOLT: src_lo = `EE_VOLT_LO;
      `FC_SPEC_INFO: src_lo = `EE_SPEC_LO;
      `FC_BUILD_DATE: src_lo = `EE_DATE_LO;
      `FC_SERIAL: src_lo = `EE_SERIAL_LO;
      default: src_lo = `EE_MAKER_LO;
    endcase
  end
  // error classification, most urgent first
  always_comb begin
    if (store_busy) begin
      err_d = `ERR_BUSY;
    end else if ((cmd.code >= `FC_RSV_LO && cmd.code <= `FC_RSV_HI) || cmd.code >= `FC_MFR_LO) begin
      err_d = `ERR_RESERVED;
    end else if (!is_word && cmd.code != `FC_MAKER) begin
      err_d = `ERR_UNSUPPORTED;
    end else if (cmd.write && cmd.len > `MAX_BLOCK) begin
      err_d = `ERR_OVERFLOW;
    end else if (cmd.write && cmd.len != exp_len) begin
      err_d = `ERR_BAD_SIZE;
    end else if (cmd.write) begin
      err_d = `ERR_DENIED;
    end else if (from_eeprom && !eeprom_load_valid) begin
      err_d = `ERR_UNKNOWN;
    end else begin
      err_d = `ERR_OK;
    end
  end
  // error field follows each processed code
  always_ff @(posedge mclk) begin
    if (reset) begin
      err_q <= `ERR_OK;
    end else if (accept) begin
      err_q <= err_d;
    end
  end
  // status word: alarms, four flags, reserved zero, error
  always_ff @(posedge mclk) begin
    if (reset) begin
      status_word_q <= 16'h0000;
    end else begin
      status_word_q <= {alarm_bits, eeprom_load_valid, not_charging, fully_charged, fully_discharged,
                        1'b0, err_q};
    end
  end

  // ==========================================================
  // answer sequencer
  batt_pkg::state_type state_q; // sequencer state
  logic [6:0] rd_addr_q; // image read address
  logic [7:0] rd_data; // image read data
  logic [3:0] issue_cnt_q; // addresses still to issue
  logic [3:0] got_q; // image bytes received
  logic issue_q; // address issued last edge
  logic data_v_q; // rd_data holds a requested byte
  logic block_q; // string answer in progress
  logic [7:0] lo_q; // first byte of word answer
  shadow_mem u_image (
    .mclk(mclk), .wr_en(ee_wr_valid), .wr_addr(ee_wr_addr), .wr_data(ee_wr_data),
    .rd_addr(rd_addr_q), .rd_data_q(rd_data));
  always_ff @(posedge mclk) begin
    if (reset) begin
      state_q <= batt_pkg::ST_IDLE;
      cmd_ready_q <= 1'b0;
      rsp_valid_q <= 1'b0;
      rsp_q <= '0;
      rd_addr_q <= 7'h00;
      issue_cnt_q <= 4'h0;
      got_q <= 4'h0;
      issue_q <= 1'b0;
      data_v_q <= 1'b0;
      block_q <= 1'b0;
      lo_q <= 8'h00;
    end else begin
      rsp_valid_q <= 1'b0;
      data_v_q <= issue_q;
      unique case (state_q)
        batt_pkg::ST_IDLE: begin
          cmd_ready_q <= 1'b1;
          issue_q <= 1'b0;
          if (accept) begin
            rsp_q.err <= err_d;
            rsp_q.last <= 1'b1;
            rsp_q.data <= 16'h0000;
            if (err_d != `ERR_OK) begin
              // refused code: answer at once with error only
              rsp_valid_q <= 1'b1;
            end else if (cmd.code == `FC_STATUS) begin
              rsp_valid_q <= 1'b1;
              rsp_q.data <= {alarm_bits, eeprom_load_valid, not_charging, fully_charged,
                             fully_discharged, 1'b0, `ERR_OK};
            end else if (cmd.code == `FC_CYCLES) begin
              rsp_valid_q <= 1'b1;
              rsp_q.data <= wear_cycle_total_q;
            end else begin
              // start streaming from the image
              cmd_ready_q <= 1'b0;
              state_q <= batt_pkg::ST_RUN;
              rd_addr_q <= src_lo;
              issue_q <= 1'b1;
              got_q <= 4'h0;
              block_q <= cmd.code == `FC_MAKER;
              issue_cnt_q <= (cmd.code == `FC_MAKER) ? 4'(`MAKER_LEN - 6'h01) : 4'h1;
              if (cmd.code == `FC_MAKER) begin
                // length byte leads the string
                rsp_valid_q <= 1'b1;
                rsp_q.last <= 1'b0;
                rsp_q.data <= {10'h000, `MAKER_LEN};
              end
            end
          end
        end
        batt_pkg::ST_RUN: begin
          if (issue_cnt_q != 4'h0) begin
            rd_addr_q <= rd_addr_q + 7'h01;
            issue_cnt_q <= issue_cnt_q - 4'h1;
          end else begin
            issue_q <= 1'b0;
          end
          if (data_v_q) begin
            got_q <= got_q + 4'h1;
            if (block_q) begin
              // one string byte per cycle
              rsp_valid_q <= 1'b1;
              rsp_q.data <= {8'h00, rd_data};
              rsp_q.last <= got_q == 4'(`MAKER_LEN - 6'h01);
              if (got_q == 4'(`MAKER_LEN - 6'h01)) begin
                state_q <= batt_pkg::ST_IDLE;
                cmd_ready_q <= 1'b1;
              end
            end else if (got_q == 4'h0) begin
              lo_q <= rd_data;
            end else begin
              // word done: low byte first in the image
              rsp_valid_q <= 1'b1;
              rsp_q.data <= {rd_data, lo_q};
              rsp_q.last <= 1'b1;
              state_q <= batt_pkg::ST_IDLE;
              cmd_ready_q <= 1'b1;
            end
          end
        end
      endcase
    end
  end

  // ==========================================================
  // checks
  AST_LOAD_FLAG: assert property (@(posedge mclk) disable iff (reset)
    ee_load_ok |-> ##2 status_word_q[7]) else $error("load flag not shown");
  AST_BAD_LOAD: assert property (@(posedge mclk) disable iff (reset)
    ee_load_bad && !ee_load_ok |=> !eeprom_load_valid) else $error("bad load kept flag");
  AST_IDLE_FLAG: assert property (@(posedge mclk) disable iff (reset)
    charging_seen && !not_charging_seen |-> ##2 !status_word_q[6]) else $error("charging not shown");
  AST_FULL_CLEAR: assert property (@(posedge mclk) disable iff (reset)
    fc_clear_hit && !charge_termination && !overcharge_seen |=> !fully_charged) else $error("full kept");
  AST_EMPTY_SET_WINS: assert property (@(posedge mclk) disable iff (reset)
    second_end_voltage_threshold && dsg_clear_hit |=> fully_discharged) else $error("set lost");
  AST_DENIED: assert property (@(posedge mclk) disable iff (reset)
    accept && !store_busy && cmd.write && cmd.code == `FC_SERIAL && cmd.len == `WORD_LEN
    |=> err_q == `ERR_DENIED && rsp_valid_q) else $error("denied not reported");
  AST_RESERVED: assert property (@(posedge mclk) disable iff (reset)
    accept && !store_busy && cmd.code == `FC_RSV_HI |=> err_q == `ERR_RESERVED) else $error("reserved missed");
  AST_UNSUP: assert property (@(posedge mclk) disable iff (reset)
    accept && !store_busy && cmd.code == 8'h10 |=> err_q == `ERR_UNSUPPORTED) else $error("unsupported missed");
  AST_SATURATE: assert property (@(posedge mclk) disable iff (reset)
    wear_cycle_total_q == `CYCLES_MAX && !ee_wr_valid |=> wear_cycle_total_q == `CYCLES_MAX)
    else $error("cycle count wrapped");
  AST_STORE: assert property (@(posedge mclk) disable iff (reset)
    cycle_step && wear_cycle_total_q != `CYCLES_MAX && !ee_wr_valid
    |-> ##2 ee_store_valid_q && ee_store_addr_q == `EE_CYCLES_LO) else $error("count not stored");
  AST_WORD_TIME: assert property (@(posedge mclk) disable iff (reset)
    accept && err_d == `ERR_OK && cmd.code == `FC_SERIAL |-> ##4 rsp_valid_q && rsp_q.last)
    else $error("word answer late");
  COV_STRING: cover property (@(posedge mclk) disable iff (reset) rsp_valid_q && block_q && rsp_q.last);
  COV_FULL: cover property (@(posedge mclk) disable iff (reset) $rose(fully_charged));
  COV_STORE: cover property (@(posedge mclk) disable iff (reset) ee_store_valid_q && ee_store_ready);
endmodule

// ===== tb/host_model.sv
`timescale 1ns/1ns
// ==========================================
// host side of the command port
module host_model (
  input wire logic mclk,
  input wire logic cmd_ready_q,
  input wire batt_pkg::rsp_type rsp_q,
  input wire logic rsp_valid_q,
  output batt_pkg::cmd_type cmd,
  output logic cmd_valid
);
  batt_pkg::rsp_type got[$]; // answers to the last request
  int stalls; // idle cycles before a request, prompt or slow

  // idle values at time zero
  initial begin
    cmd = '0;
    cmd_valid = 1'b0;
    stalls = 0;
  end

  // offer one request, hold it until taken, then gather its answers
  task automatic request(input logic wr, input logic [7:0] code, input logic [5:0] len, output bit ok);
    int n;
    ok = 1'b0;
    got.delete();
    repeat (stalls) @(posedge mclk);
    cmd <= {wr, code, len};
    cmd_valid <= 1'b1;
    // held unchanged until the edge that sees ready high
    for (n = 0; n < 50 && !ok; n++) begin
      @(posedge mclk);
      ok = cmd_ready_q;
    end
    cmd_valid <= 1'b0;
    // released request lines do not keep their last value
    cmd <= ~cmd;
    // answers are collected until the one marked last
    for (n = 0; n < 40 && ok; n++) begin
      @(posedge mclk);
      if (rsp_valid_q) got.push_back(rsp_q);
      if (rsp_valid_q && rsp_q.last) break;
    end
    ok = ok && got.size() > 0 && got[$].last === 1'b1;
  endtask
endmodule

// ===== tb/battery_status_and_identity_words_tb.sv
`timescale 1ns/1ns
`include "batt_map.svh"
// ==========================================
// self-checking bench for the status and identity words
module battery_status_and_identity_words_tb;
  logic mclk; // 100 mhz clock
  logic reset; // synchronous, active high
  batt_pkg::cmd_type cmd; // request from the host model
  logic cmd_valid; // request offered
  logic cmd_ready_q; // design can take a request
  batt_pkg::rsp_type rsp_q; // answer word or byte
  logic rsp_valid_q; // answer strobe
  logic ee_wr_valid; // image byte strobe
  logic [6:0] ee_wr_addr; // image byte address
  logic [7:0] ee_wr_data; // image byte value
  logic [6:0] ev; // cause pulses: ok, bad, chg, idle, term, over, unit
  logic low_v; // pack below second end voltage threshold
  logic [7:0] charge_percent; // relative state of charge
  logic capacity_mode; // 0 mah, 1 10 mwh
  logic [7:0] alarm_bits; // alarm byte of the status word
  logic ee_store_valid_q; // byte store request
  logic [6:0] ee_store_addr_q; // byte store address
  logic [7:0] ee_store_data_q; // byte store value
  logic ee_store_ready; // eeprom side takes the byte
  logic [15:0] status_word_q; // live status word
  logic [7:0] img [128]; // eeprom image handed to the design
  logic [14:0] stores[$]; // bytes taken by the eeprom side
  logic [3:0] fl; // expected flags: valid, idle, full, empty
  logic store_hold; // stalls the eeprom side
  int seed = 56; // fixed seed
  int miscompares = 0;
  int checks_done = 0;

  // ==========================================
  // design and host
  battery_status_and_identity_words dut_u (
    .mclk(mclk), .reset(reset), .cmd(cmd), .cmd_valid(cmd_valid), .cmd_ready_q(cmd_ready_q),
    .rsp_q(rsp_q), .rsp_valid_q(rsp_valid_q), .ee_wr_valid(ee_wr_valid), .ee_wr_addr(ee_wr_addr),
    .ee_wr_data(ee_wr_data), .ee_load_ok(ev[0]), .ee_load_bad(ev[1]), .charging_seen(ev[2]),
    .not_charging_seen(ev[3]), .charge_termination(ev[4]), .overcharge_seen(ev[5]),
    .second_end_voltage_threshold(low_v), .charge_percent(charge_percent), .capacity_mode(capacity_mode),
    .alarm_bits(alarm_bits), .dsg_unit_pulse(ev[6]), .ee_store_valid_q(ee_store_valid_q),
    .ee_store_addr_q(ee_store_addr_q), .ee_store_data_q(ee_store_data_q), .ee_store_ready(ee_store_ready),
    .status_word_q(status_word_q)
  );
  host_model host_u (
    .mclk(mclk), .cmd_ready_q(cmd_ready_q), .rsp_q(rsp_q), .rsp_valid_q(rsp_valid_q),
    .cmd(cmd), .cmd_valid(cmd_valid)
  );

  // clock generator
  initial mclk = 1'b0;
  always #5 mclk = ~mclk;

  // eeprom side: takes store bytes promptly or slowly, logs them
  always @(posedge mclk) begin
    ee_store_ready <= !store_hold && 1'($random(seed));
    if (ee_store_valid_q && ee_store_ready) stores.push_back({ee_store_addr_q, ee_store_data_q});
  end

  // ==========================================
  // helpers
  task automatic close_out();
    if (miscompares == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // one comparison, counted
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // one request through the host, slow or prompt
  task automatic ask(input logic wr, input logic [7:0] code, input logic [5:0] len);
    bit ok;
    host_u.stalls = $random(seed) & 3;
    host_u.request(wr, code, len, ok);
    if (!ok) begin
      miscompares++;
      $display("wrong value at %0t: no answer to code %h", $time, code);
      close_out();
    end
  endtask

  // word read that must succeed, error field back to ok
  task automatic rd_word(input logic [7:0] code, input logic [15:0] exp);
    ask(1'b0, code, 6'h00);
    chk(host_u.got[0].data, exp, "word");
    chk(16'(host_u.got[0].err), 16'(`ERR_OK), "word error");
    tick(3);
    chk(16'(status_word_q[2:0]), 16'h0000, "error field after success");
  endtask

  // refused request: one answer, data zero, code also in status word
  task automatic refuse(input logic wr, input logic [7:0] code, input logic [5:0] len, input logic [2:0] err);
    ask(wr, code, len);
    chk(host_u.got[0].data, 16'h0000, "refused data");
    chk(16'(host_u.got[0].err), 16'(err), "refused code");
    tick(3);
    chk(16'(status_word_q[2:0]), 16'(err), "error field");
  endtask

  // one-cycle cause pulse with a quiet edge after it
  task automatic pulse(input int b);
    ev[b] <= 1'b1;
    @(posedge mclk);
    ev <= '0;
    @(posedge mclk);
  endtask

  // optional cause, then flag expectation on the status word
  task automatic ev_check(input int b, input int f, input logic v);
    if (b >= 0) pulse(b);
    fl[f] = v;
    tick(3);
    chk(16'(status_word_q[7:4]), 16'(fl), "flags");
  endtask

  function automatic logic [15:0] pack_date(input logic [6:0] y, input logic [3:0] m, input logic [4:0] d);
    return {y, m, d};
  endfunction

  // expected identity word, low byte at the lower address
  function automatic logic [15:0] exp_word(input logic [7:0] c, input logic mode);
    logic [6:0] a;
    case (c)
      8'h18: a = mode ? `EE_CAP_MWH_LO : `EE_CAP_MAH_LO;
      8'h19: a = `EE_VOLT_LO;
      8'h1a: a = `EE_SPEC_LO;
      8'h1b: a = `EE_DATE_LO;
      default: a = `EE_SERIAL_LO;
    endcase
    return {img[a + 7'h01], img[a]};
  endfunction

  // ==========================================
  // main sequence
  initial begin
    reset = 1'b1;
    ee_wr_valid = 1'b0;
    ee_wr_addr = 7'h00;
    ee_wr_data = 8'h00;
    ev = '0;
    low_v = 1'b0;
    charge_percent = 8'h32;
    capacity_mode = 1'b0;
    store_hold = 1'b0;
    fl = 4'h0;
    for (int a = 0; a < 128; a++) img[a] = 8'($random(seed));
    img[7'h0e] = 8'hfe;
    img[7'h0f] = 8'hff;
    img[7'h3c] = 8'h03;
    img[7'h3d] = 8'h00;
    img[7'h4c] = 8'h5a;
    img[7'h15] = 8'h00;
    {img[7'h17], img[7'h16]} = pack_date(7'h13, 4'h2, 5'h19);
    alarm_bits = 8'($random(seed));
    tick(6);
    reset <= 1'b0;
    tick(2);
    ev_check(-1, 0, 1'b0);
    refuse(1'b0, `FC_SERIAL, 6'h00, `ERR_UNKNOWN);
    // image load, byte by byte, then the good-load pulse
    for (int a = 0; a < 128; a++) begin
      ee_wr_valid <= 1'b1;
      ee_wr_addr <= 7'(a);
      ee_wr_data <= img[a];
      @(posedge mclk);
    end
    ee_wr_valid <= 1'b0;
    // idle image lines no longer show the last byte
    ee_wr_addr <= ~ee_wr_addr;
    ee_wr_data <= ~ee_wr_data;
    ev_check(0, 3, 1'b1);
    rd_word(`FC_STATUS, {alarm_bits, fl, 4'h0});
    rd_word(`FC_CYCLES, 16'hfffe);
    for (int i = 0; i < 15; i++) begin
      capacity_mode <= i[2];
      rd_word(8'h18 + 8'(i % 5), exp_word(8'h18 + 8'(i % 5), i[2]));
    end
    ask(1'b0, `FC_MAKER, 6'h00);
    chk(16'(host_u.got.size()), 16'h000c, "string answers");
    chk(16'(host_u.got[0].data[7:0]), 16'(`MAKER_LEN), "length byte");
    for (int i = 0; i < 11; i++) chk(16'(host_u.got[i + 1].data[7:0]), 16'(img[32 + i]), "string byte");
    refuse(1'b0, 8'h1d, 6'h00, `ERR_RESERVED);
    refuse(1'b1, 8'h1f, 6'h02, `ERR_RESERVED);
    refuse(1'b0, 8'h35, 6'h00, `ERR_RESERVED);
    refuse(1'b0, 8'h45, 6'h00, `ERR_RESERVED);
    refuse(1'b0, 8'h15, 6'h00, `ERR_UNSUPPORTED);
    refuse(1'b0, 8'h10, 6'h00, `ERR_UNSUPPORTED);
    refuse(1'b1, `FC_SERIAL, 6'h21, `ERR_OVERFLOW);
    refuse(1'b1, `FC_DESIGN_VOLT, 6'h03, `ERR_BAD_SIZE);
    refuse(1'b1, `FC_MAKER, 6'h02, `ERR_BAD_SIZE);
    refuse(1'b1, `FC_DESIGN_VOLT, 6'h02, `ERR_DENIED);
    refuse(1'b1, `FC_MAKER, 6'h0c, `ERR_DENIED);
    refuse(1'b1, `FC_SERIAL, 6'h02, `ERR_DENIED);
    rd_word(`FC_SERIAL, {img[7'h19], img[7'h18]});
    // flag causes and their clear conditions, at the boundaries
    ev_check(3, 2, 1'b1);
    ev_check(2, 2, 1'b0);
    charge_percent <= 8'h5b;
    ev_check(4, 1, 1'b1);
    charge_percent <= 8'h5a;
    ev_check(-1, 1, 1'b0);
    charge_percent <= 8'h64;
    ev_check(5, 1, 1'b1);
    charge_percent <= 8'h13;
    ev_check(-1, 1, 1'b0);
    low_v <= 1'b1;
    ev_check(-1, 0, 1'b1);
    low_v <= 1'b0;
    ev_check(-1, 0, 1'b1);
    charge_percent <= `DSG_CLEAR_PCT;
    ev_check(-1, 0, 1'b0);
    // low voltage while already at the release level: set wins
    low_v <= 1'b1;
    ev_check(-1, 0, 1'b1);
    low_v <= 1'b0;
    ev_check(-1, 0, 1'b0);
    rd_word(`FC_STATUS, {alarm_bits, fl, 4'h0});
    // cycle step with the eeprom side stalled: busy, then stored back
    store_hold = 1'b1;
    repeat (3) pulse(6);
    tick(4);
    refuse(1'b0, `FC_DESIGN_VOLT, 6'h00, `ERR_BUSY);
    store_hold = 1'b0;
    for (int i = 0; i < 60 && stores.size() < 2; i++) tick(1);
    chk(16'(stores.size()), 16'h0002, "store count");
    if (stores.size() < 2) close_out();
    chk({1'b0, stores[0]}, {1'b0, `EE_CYCLES_LO, 8'hff}, "count store low");
    chk({1'b0, stores[1]}, {1'b0, `EE_CYCLES_HI, 8'hff}, "count store high");
    rd_word(`FC_CYCLES, `CYCLES_MAX);
    repeat (3) pulse(6);
    tick(20);
    rd_word(`FC_CYCLES, `CYCLES_MAX);
    ev_check(1, 3, 1'b0);
    refuse(1'b0, `FC_SPEC_INFO, 6'h00, `ERR_UNKNOWN);
    close_out();
  end
endmodule
